// file: hw/dev_io_port.sv
// device end: command decode, conversion sequencer and shared pin drivers
`timescale 1ns/1ps
module dev_io_port
  import io_pin_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  spi_link_if.device link,
  output logic conv_start_o,
  output logic [3:0] conv_channel_o,
  input wire logic [11:0] conv_result_i,
  input wire logic conv_done_i,
  output logic frame_valid_o,
  output logic [15:0] frame_word_o
);
  logic start, done;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  logic [3:0] addr;
  logic is_reg;
  logic [8:0] seq_select;
  logic seq_repeat;
  logic seq_active;
  logic [3:0] seq_index;
  logic [4:0] first_hit, after_hit, write_hit;
  logic [7:0] out_en;
  logic busy_en;
  logic [7:0] out_data;
  logic [7:0] open_drain;
  logic [7:0] in_en;
  logic [7:0] rdbk_mask;
  logic rdbk_armed;
  logic converting;
  logic [15:0] result_word;
  logic result_valid;
  logic [7:0] pin_m, pin_s;
  logic [7:0] next_pin_out, next_pin_oe_n;

  // lowest set bit of mask at or above from; msb of the answer says found
  function automatic logic [4:0] next_set(input logic [8:0] mask, input logic [3:0] from);
    logic [4:0] hit;
    hit = 5'h00;
    for (int i = 8; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= from)) begin
        hit = {1'b1, 4'(i)};
      end
    end
    return hit;
  endfunction : next_set

  spi_frame_shifter u_shifter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sclk_i(link.sclk),
    .cs_n_i(link.cs_n),
    .mosi_i(link.mosi),
    .tx_word_i(tx_word),
    .miso_o(link.miso),
    .start_o(start),
    .done_o(done),
    .rx_word_o(rx_word)
  );

  // frames with the top bit set are dac loads and bypass the register decode
  assign addr = rx_word[ADDR_HI:ADDR_LO];
  assign is_reg = done && !rx_word[DAC_FLAG_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // every accepted frame is passed to the user side so dac loads still run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_valid_o <= 1'b0;
      frame_word_o <= 16'h0000;
    end else begin
      frame_valid_o <= done;
      if (done) begin
        frame_word_o <= rx_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: the frame start both shifts out the old result and converts
  assign first_hit = next_set(seq_select, 4'h0);
  assign after_hit = next_set(seq_select, 4'(seq_index + 4'h1));
  // first channel of a freshly written selection; msb clear means nothing selected
  assign write_hit = next_set({rx_word[SEQ_TEMP_BIT], rx_word[7:0]}, 4'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_select <= SEQ_RESET;
      seq_repeat <= 1'b0;
      seq_active <= 1'b0;
      seq_index <= 4'h0;
    end else if (is_reg && addr == REG_SEQ) begin
      seq_repeat <= rx_word[SEQ_REPEAT_BIT];
      seq_select <= {rx_word[SEQ_TEMP_BIT], rx_word[7:0]};
      // start from the lowest included channel; an all-clear write stops it
      seq_index <= write_hit[3:0];
      seq_active <= write_hit[4];
    end else if (start && seq_active) begin
      if (after_hit[4]) begin
        seq_index <= after_hit[3:0];
      end else if (seq_repeat) begin
        seq_index <= first_hit[3:0];
      end else begin
        seq_active <= 1'b0;
      end
    end
  end

  // conversion request to the analog side, one pulse per frame start while the sequence is active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
      conv_channel_o <= 4'h0;
    end else begin
      conv_start_o <= start && seq_active;
      if (start && seq_active) begin
        conv_channel_o <= seq_index;
      end
    end
  end

  // a result waits for the next frame; done sets valid, the frame start
  // that sends it clears it, and a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converting <= 1'b0;
      result_valid <= 1'b0;
      result_word <= 16'h0000;
    end else begin
      if (conv_start_o) begin
        converting <= 1'b1;
      end else if (conv_done_i) begin
        converting <= 1'b0;
      end
      if (conv_done_i && converting) begin
        result_valid <= 1'b1;
        if (conv_channel_o == TEMP_INDEX) begin
          result_word <= {TEMP_TAG, conv_result_i};
        end else begin
          result_word <= {1'b0, conv_channel_o[2:0], conv_result_i};
        end
      end else if (start && !rdbk_armed) begin
        result_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_en <= PIN_CFG_RESET;
      busy_en <= 1'b0;
      open_drain <= PIN_CFG_RESET;
      in_en <= PIN_CFG_RESET;
    end else if (is_reg) begin
      if (addr == REG_OUT_CFG) begin
        out_en <= rx_word[7:0];
        busy_en <= rx_word[BUSY_EN_BIT];
      end
      if (addr == REG_OPEN_DRAIN) begin
        open_drain <= rx_word[7:0];
      end
      // a readback request selects pins to report, not the input set
      if (addr == REG_IN_CFG && !rx_word[READBACK_BIT]) begin
        in_en <= rx_word[7:0];
      end
    end
  end

  // output data: bits aimed at pins that are not outputs keep old value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_data <= PIN_CFG_RESET;
    end else if (is_reg && addr == REG_OUT_DATA) begin
      out_data <= (rx_word[7:0] & out_en) | (out_data & ~out_en);
    end
  end

  // readback arms on the request and is spent by the very next frame start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdbk_armed <= 1'b0;
      rdbk_mask <= PIN_CFG_RESET;
    end else if (is_reg && addr == REG_IN_CFG && rx_word[READBACK_BIT]) begin
      rdbk_armed <= 1'b1;
      rdbk_mask <= rx_word[7:0];
    end else if (start) begin
      rdbk_armed <= 1'b0;
    end
  end

  // pin levels come from outside, so they are synchronised before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m <= 8'h00;
      pin_s <= 8'h00;
    end else begin
      pin_m <= link.pin_level;
      pin_s <= pin_m;
    end
  end

  // readback beats a pending result; the result then goes one frame later unless the readback frame's own conversion overwrites it
  always_comb begin
    if (rdbk_armed) begin
      tx_word = {8'h00, pin_s & rdbk_mask};
    end else if (result_valid) begin
      tx_word = result_word;
    end else begin
      tx_word = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers: an input setting overrides an output setting on a pin
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    logic drive, level;
    assign drive = out_en[i] & ~in_en[i];
    if (i == BUSY_PIN) begin : g_busy
      assign level = busy_en ? ~converting : out_data[i];
    end else begin : g_plain
      assign level = out_data[i];
    end
    // open drain only ever drives low; push/pull drives both levels
    assign next_pin_out[i] = open_drain[i] ? 1'b0 : level;
    assign next_pin_oe_n[i] = ~drive | (open_drain[i] & level);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.pin_out <= 8'h00;
      link.pin_oe_n <= 8'hFF;
    end else begin
      link.pin_out <= next_pin_out;
      link.pin_oe_n <= next_pin_oe_n;
    end
  end
endmodule : dev_io_port

// file: hw/host_spi_master.sv
// host end: wishbone register slave that sends 16-bit frames over the link
`timescale 1ns/1ps
module host_spi_master
  import io_pin_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_SCLK_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  spi_link_if.host link
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LEAD = 5'b00010,
    ST_BITS = 5'b00100,
    ST_TRAIL = 5'b01000,
    ST_GAP = 5'b10000
  } host_state_t;

  host_state_t state;
  logic [7:0] timer;
  logic [3:0] bit_cnt;
  logic [15:0] cmd_sr;
  logic [15:0] resp;
  logic miso_m, miso_s;
  logic req, wr_cmd, expired;

  assign req = wb_cyc_i && wb_stb_i;
  // commands are taken only at the acking edge and only when idle
  assign wr_cmd = req && wb_ack_o && wb_we_i && wb_adr_i == WB_CMD && (&wb_sel_i[1:0])
                  && state == ST_IDLE;
  assign expired = timer == 8'(HALF_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      case (wb_adr_i)
        WB_STATUS: wb_dat_o <= {31'h00000000, state != ST_IDLE};
        WB_RESP: wb_dat_o <= {16'h0000, resp};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // returning data is a pin, so it is synchronised before sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_m <= link.miso;
      miso_s <= miso_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine; half period must cover the device's pin sync delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      timer <= 8'h00;
      bit_cnt <= 4'h0;
      cmd_sr <= 16'h0000;
      resp <= 16'h0000;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end else begin
      timer <= expired ? 8'h00 : 8'(timer + 8'h01);
      case (state)
        ST_IDLE: begin
          timer <= 8'h00;
          if (wr_cmd) begin
            cmd_sr <= wb_dat_i[15:0];
            link.mosi <= wb_dat_i[15];
            link.cs_n <= 1'b0;
            bit_cnt <= 4'h0;
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (expired) begin
            link.sclk <= 1'b1;
            resp <= {resp[14:0], miso_s};
            state <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (expired && link.sclk) begin
            link.sclk <= 1'b0;
            if (bit_cnt == 4'(FRAME_BITS - 1)) begin
              state <= ST_TRAIL;
            end else begin
              cmd_sr <= {cmd_sr[14:0], 1'b0};
              link.mosi <= cmd_sr[14];
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end
          end else if (expired) begin
            link.sclk <= 1'b1;
            resp <= {resp[14:0], miso_s};
          end
        end
        ST_TRAIL: begin
          if (expired) begin
            link.cs_n <= 1'b1;
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (expired) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : host_spi_master

// file: hw/io_pin_pkg.sv
// constants shared by both ends of the shared-pin serial control link
// How it works
// - addr 0b0010, bit15 zero writes sequence register
// - bit 9 repeats sequence, zero runs once
// - bit 8 adds temperature indicator to sequence
// - bits 7-0 include matching channels
// - result: bit15 zero, channel, 12-bit value; temperature results carry tag 0b1000 in bits 15-12
// - every shared pin works as digital I/O
// - addr 0b1000 bits 7-0 select outputs
// - data bits for non-output pins ignored
// - one drives high, zero drives low
// - push/pull drives both levels, per pin
// - open-drain pulls low, releases for one
// - input config bit makes pin an input
// - readback request returns pins next transfer
// - unselected readback bits return zero
// - readback transfer still executes its command
// - out config bit 8 makes pin7 busy; code shows busy only with out config bit 7 set and input config bit 7 clear
// - host keeps out config bits 10-9 zero
// - ascending channels, one per frame start
// - result returned one transfer after start; an armed readback goes first and the result waits or is overwritten
// - busy low while converting, high after
// - host clears sequence before new selection
package io_pin_pkg;
  localparam int FRAME_BITS = 16;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 11;
  localparam int DAC_FLAG_BIT = 15;
  localparam logic [3:0] REG_SEQ = 4'h2;
  localparam logic [3:0] REG_OUT_CFG = 4'h8;
  localparam logic [3:0] REG_OUT_DATA = 4'h9;
  localparam logic [3:0] REG_IN_CFG = 4'hA;
  localparam logic [3:0] REG_OPEN_DRAIN = 4'hC;
  localparam int SEQ_REPEAT_BIT = 9;
  localparam int SEQ_TEMP_BIT = 8;
  localparam int READBACK_BIT = 10;
  localparam int BUSY_EN_BIT = 8;
  localparam int BUSY_PIN = 7;
  localparam logic [3:0] TEMP_INDEX = 4'h8;
  localparam logic [3:0] TEMP_TAG = 4'h8;
  localparam logic [7:0] PIN_CFG_RESET = 8'h00;
  localparam logic [8:0] SEQ_RESET = 9'h000;
  localparam int HALF_SCLK_CYCLES = 8;
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_STATUS = 8'h04;
  localparam logic [7:0] WB_RESP = 8'h08;
endpackage : io_pin_pkg

// file: hw/spi_frame_shifter.sv
// device-side frame shifter: samples the link pins and moves 16-bit words
`timescale 1ns/1ps
module spi_frame_shifter
  import io_pin_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [15:0] tx_word_i,
  output logic miso_o,
  output logic start_o,
  output logic done_o,
  output logic [15:0] rx_word_o
);
  logic sclk_m, sclk_s, sclk_d, cs_m, cs_s, cs_d, mosi_m, mosi_s;
  logic rise, fall, stop;
  logic [4:0] count;
  logic [15:0] rx_sr;
  logic [15:0] tx_sr;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; all three pins share depth so they stay aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      {cs_m, cs_s, cs_d} <= 3'h7;
      {mosi_m, mosi_s} <= 2'h0;
    end else begin
      {sclk_m, sclk_s, sclk_d} <= {sclk_i, sclk_m, sclk_s};
      {cs_m, cs_s, cs_d} <= {cs_n_i, cs_m, cs_s};
      {mosi_m, mosi_s} <= {mosi_i, mosi_m};
    end
  end

  assign start_o = cs_d & ~cs_s;
  assign stop = ~cs_d & cs_s;
  assign rise = ~sclk_d & sclk_s & ~cs_s;
  assign fall = sclk_d & ~sclk_s & ~cs_s;

  ////////////////////////////////////////////////////////////////////////////
  // receive on rising clock edges; count saturates so long frames are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 5'h00;
      rx_sr <= 16'h0000;
    end else if (start_o) begin
      count <= 5'h00;
    end else if (rise) begin
      rx_sr <= {rx_sr[14:0], mosi_s};
      if (count != 5'h1F) begin
        count <= 5'(count + 5'h01);
      end
    end
  end

  // only a frame of exactly sixteen bits is handed on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      rx_word_o <= 16'h0000;
    end else begin
      done_o <= stop && (count == 5'(FRAME_BITS));
      if (stop) begin
        rx_word_o <= rx_sr;
      end
    end
  end

  // transmit: msb shown at frame start, next bit after each falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sr <= 16'h0000;
      miso_o <= 1'b0;
    end else if (start_o) begin
      tx_sr <= tx_word_i;
      miso_o <= tx_word_i[15];
    end else if (fall) begin
      tx_sr <= {tx_sr[14:0], 1'b0};
      miso_o <= tx_sr[14];
    end
  end
endmodule : spi_frame_shifter

// file: hw/spi_link_if.sv
// serial link and shared pins between the host end and the device end
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] pin_ext;
  logic [7:0] pin_level;
  // undriven pins take the level the outside world puts on them
  assign pin_level = (pin_out & ~pin_oe_n) | (pin_ext & pin_oe_n);
  modport device (input sclk, input cs_n, input mosi, input pin_level,
                  output miso, output pin_out, output pin_oe_n);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_link_if

// file: test/io_link_chk.sv
// link and pin checker placed beside the interface that joins the two ends
`timescale 1ns/1ps
module io_link_chk
  import io_pin_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_SCLK_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n
);
  int hi_run;
  int lo_run;
  int gap_run;
  int rises;
  logic sclk_q;
  // run lengths; the gap starts at HALF_CYCLES so the first frame after reset passes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_run <= 0;
      lo_run <= 0;
      gap_run <= HALF_CYCLES;
      rises <= 0;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      hi_run <= sclk ? hi_run + 1 : 0;
      lo_run <= (!sclk && !cs_n) ? lo_run + 1 : 0;
      gap_run <= !cs_n ? 0 : (gap_run < 1000 ? gap_run + 1 : gap_run);
      rises <= cs_n ? 0 : rises + int'(sclk && !sclk_q);
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high outside frame");
  property p_mosi_hold; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved, sclk high");
  property p_miso_hold; sclk && $past(sclk) |-> $stable(miso); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved, sclk high");
  property p_sixteen; $rose(cs_n) |-> rises == FRAME_BITS; endproperty
  a_sixteen: assert property (p_sixteen) else $error("frame not 16 bits");
  property p_hi_half; $fell(sclk) |-> hi_run == HALF_CYCLES; endproperty
  a_hi_half: assert property (p_hi_half) else $error("sclk high phase length");
  property p_lo_half; $rose(sclk) |-> lo_run == HALF_CYCLES; endproperty
  a_lo_half: assert property (p_lo_half) else $error("sclk low phase length");
  property p_gap; $fell(cs_n) |-> gap_run >= HALF_CYCLES; endproperty
  a_gap: assert property (p_gap) else $error("frames too close");
  // only the busy pin may move inside a frame; the others wait for a write
  property p_pins_quiet;
    !cs_n && !$past(cs_n) |-> $stable(pin_out[6:0]) && $stable(pin_oe_n[6:0]);
  endproperty
  a_pins_quiet: assert property (p_pins_quiet) else $error("pin moved in frame");
endmodule : io_link_chk

// file: test/tb_top.sv
// testbench: wishbone host end driving the device end across the link
`timescale 1ns/1ps
module tb_top
  import io_pin_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] pin_ext = 8'h00;
  logic conv_start_o;
  logic [3:0] conv_channel_o;
  logic [11:0] conv_result_i = 12'h000;
  logic conv_done_i = 1'b0;
  logic frame_valid_o;
  logic [15:0] frame_word_o;
  logic [15:0] last_rx = 16'h0000;
  logic [3:0] chan_log [$];
  logic busy_watch = 1'b0;
  int conv_wait = 0;
  int fail_count = 0;
  int compares = 0;
  always #5 clk_i = ~clk_i;
  spi_link_if link();
  assign link.pin_ext = pin_ext;
  host_spi_master #(.HALF_CYCLES(HALF_SCLK_CYCLES)) u_host_spi_master (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link));
  dev_io_port u_dev_io_port (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
    .conv_result_i(conv_result_i), .conv_done_i(conv_done_i),
    .frame_valid_o(frame_valid_o), .frame_word_o(frame_word_o));
  io_link_chk #(.HALF_CYCLES(HALF_SCLK_CYCLES)) u_io_link_chk (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .pin_out(link.pin_out), .pin_oe_n(link.pin_oe_n));
  ////////////////////////////////////////////////////////////////
  // converter stand-in: result 15 cycles after start, busy pin probed both sides of done
  always @(posedge clk_i) begin
    conv_done_i <= (conv_wait == 6);
    if (conv_wait > 0) conv_wait <= conv_wait - 1;
    if (conv_start_o === 1'b1) begin
      chan_log.push_back(conv_channel_o);
      conv_result_i <= {conv_channel_o, 8'hC3};
      conv_wait <= 20;
    end
    if (busy_watch && conv_wait == 8) check({15'h0, link.pin_level[7]}, 16'h0000);
    if (busy_watch && conv_wait == 1) check({15'h0, link.pin_level[7]}, 16'h0001);
  end
  // keep the last frame the device end handed to its user side
  always @(posedge clk_i) begin
    if (frame_valid_o === 1'b1) last_rx <= frame_word_o;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; request held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    wb_sel <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_cycle
  // a frame is refused while busy, so wait for idle before taking the answer
  task automatic send(input logic [15:0] word, output logic [15:0] resp);
    logic [31:0] d;
    wb_cycle(1'b1, WB_CMD, {16'h0000, word}, d);
    do wb_cycle(1'b0, WB_STATUS, 32'h0, d); while (d[0] !== 1'b0);
    wb_cycle(1'b0, WB_RESP, 32'h0, d);
    resp = d[15:0];
  endtask : send
  function automatic logic [15:0] reg_frame(input logic [3:0] a, input logic [10:0] v);
    return {1'b0, a, v};
  endfunction : reg_frame
  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  // watchdog: the tests need under 15000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] r;
    logic [31:0] d;
    logic [15:0] exp_once [4] = '{16'h00C3, 16'h22C3, 16'h88C3, 16'h0000};
    logic [3:0] exp_chan [3] = '{4'h0, 4'h2, TEMP_INDEX};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b1, 8'h10, 32'hFFFF, d);
    wb_cycle(1'b0, 8'h10, 32'h0, d);
    check(d[15:0], 16'h0000);
    check({8'h00, link.pin_oe_n}, 16'h00FF);
    pin_ext <= 8'hF0;
    send(reg_frame(REG_OUT_CFG, 11'h00F), r);
    send(reg_frame(REG_OUT_DATA, 11'h0A5), r);
    check({8'h00, link.pin_oe_n}, 16'h00F0);
    check({8'h00, link.pin_level}, 16'h00F5);
    // new outputs must not show the data bits written while they were inputs
    send(reg_frame(REG_OUT_CFG, 11'h0FF), r);
    check({8'h00, link.pin_level}, 16'h0005);
    pin_ext <= 8'hFF;
    send(reg_frame(REG_OPEN_DRAIN, 11'h003), r);
    send(reg_frame(REG_OUT_DATA, 11'h001), r);
    check({8'h00, link.pin_oe_n}, 16'h0001);
    check({8'h00, link.pin_level}, 16'h0001);
    send(reg_frame(REG_OPEN_DRAIN, 11'h000), r);
    pin_ext <= 8'h6A;
    send(reg_frame(REG_IN_CFG, 11'h0F0), r);
    check({8'h00, link.pin_level}, 16'h0061);
    send(reg_frame(REG_IN_CFG, 11'h430), r);
    send(16'h8ABC, r);
    check(r, 16'h0020);
    check(last_rx, 16'h8ABC);
    send(16'h0000, r);
    check(r, 16'h0000);
    // busy on the top pin, then a one-shot sequence with temperature
    send(reg_frame(REG_IN_CFG, 11'h000), r);
    pin_ext <= 8'h00;
    send(reg_frame(REG_OUT_CFG, 11'h180), r);
    check({15'h0, link.pin_level[7]}, 16'h0001);
    busy_watch = 1'b1;
    send(reg_frame(REG_SEQ, 11'h105), r);
    send(16'h0000, r);
    foreach (exp_once[i]) begin
      send(16'h0000, r);
      check(r, exp_once[i]);
    end
    check(16'(chan_log.size()), 16'h0003);
    foreach (exp_chan[i]) check({12'h000, chan_log[i]}, {12'h000, exp_chan[i]});
    // stop first, then a repeating single channel
    send(reg_frame(REG_SEQ, 11'h000), r);
    chan_log.delete();
    send(reg_frame(REG_SEQ, 11'h280), r);
    repeat (4) send(16'h0000, r);
    check(r, 16'h77C3);
    check(16'(chan_log.size()), 16'h0004);
    send(reg_frame(REG_SEQ, 11'h000), r);
    tally_and_finish();
  end
endmodule : tb_top
